// ### hdl/sss_shifter.v
// Overview of operation
// - Reset clears control: internal, receive, MSB first
// - Clock source bit picks prescaler or pin
// - Order bit picks MSB or LSB first
// - Mode bit picks receive-only or transmit/receive
// - Shifter and counter run only when enabled
// - Writing start bit clears counter, starts shift
// - Edge bit swaps transmit and sample edges
// - Internal rate is pclk/4/(prescale+1)
// - Every transfer moves exactly eight bits
// - External source turns clock pin to input
// - Send and receive share shift clocks
// - Receive-only mode keeps serial output idle
// - Internal clock starts right after start write
// - Finished byte sets done flag and request
// - Request needs the interrupt enable bit
// - Next transfer needs a new start write
// - Servicing the interrupt clears the flag
//
// Chosen here: the APB slave port.
`include "sss_defs.vh"
`default_nettype none

// ****************************************
// Usage notes
// ****************************************
// Registers sit at word indices; the byte address is four times the
// index, so the bus decode ignores paddr[1:0].
// Unmapped addresses answer with pslverr; writes to them are lost
// and reads return zero.
// Every bus answer takes exactly one wait state.
// The start bit is a command: it is never stored and reads back as
// the busy state of the engine.
// A start is honoured only when the same write keeps shift enable
// set; clearing shift enable in mid-byte pauses the engine.
// The data register takes a new byte only while the engine is idle;
// a write during a byte is dropped without a bus error.
// With the internal source the pin clock idles at the edge select
// level, so the first edge of a byte is always a sample edge.
// With the external source the partner must park the clock at that
// same idle level before the start write.
// Serial inputs pass two flops, so received bits lag the pin by two
// clocks; a prescale of zero leaves no margin for a slave that
// changes its data on our transmit edge. Use one or more there.
// An external clock is seen three clocks late; its half period must
// be four system clocks or longer.
// Receive-only mode holds the data output at its idle level.
// The done flag rises in the clock after the eighth sample edge;
// when that set meets a service acknowledge, the set wins.

module sss_shifter #(
    parameter PS_W = 8                      // Prescaler width
) (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    ce,
    // APB slave
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`SSS_ADDR_W-1:0]  paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output reg                     pready,
    output reg                     pslverr,
    // Serial pins
    input  wire                    sck_in,
    output reg                     sck_out,
    output reg                     sck_oe_n,
    input  wire                    si_in,
    output reg                     so_out,
    // Interrupt
    input  wire                    svc_ack,
    output reg                     irq_req
);

    // ****************************************
    // Functions
    // ****************************************

    // Word index match on the APB address
    function hit;
        input [`SSS_ADDR_W-1:0] addr;
        input [`SSS_ADDR_W-3:0] idx;
        begin
            hit = (addr[`SSS_ADDR_W-1:2] == idx);
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg [`SSS_CTRL_W-1:0] ctrl_reg;         // Control bits
    reg [PS_W-1:0]        ps_reg;           // Prescaler value
    reg [7:0]             shd_reg;          // Shift data
    reg [2:0]             cnt_reg;          // Bit clock counter
    reg                   busy_reg;         // Transfer in progress
    reg                   flag_reg;         // Transfer done flag
    reg                   ie_reg;           // Interrupt enable
    reg                   sck_s1_reg;       // Clock pin sync, first
    reg                   sck_s2_reg;       // Clock pin sync, second
    reg                   sck_s3_reg;       // Delayed for edge detect
    reg                   si_s1_reg;        // Data pin sync, first
    reg                   si_s2_reg;        // Data pin sync, second

    // ****************************************
    // Decoded controls
    // ****************************************
    wire clk_src   = ctrl_reg[`SSS_B_CLK_SRC];
    wire lsb_first = ctrl_reg[`SSS_B_BIT_ORDER];
    wire xfer_mode = ctrl_reg[`SSS_B_XFER_MODE];
    wire shift_en  = ctrl_reg[`SSS_B_SHIFT_EN];
    wire edge_sel  = ctrl_reg[`SSS_B_EDGE_SEL];

    // ****************************************
    // APB decode
    // ****************************************
    wire sel_ctrl  = hit(paddr, `SSS_IDX_CTRL);
    wire sel_ps    = hit(paddr, `SSS_IDX_PRESCALE);
    wire sel_data  = hit(paddr, `SSS_IDX_DATA);
    wire sel_stat  = hit(paddr, `SSS_IDX_STATUS);
    wire mapped    = sel_ctrl | sel_ps | sel_data | sel_stat;
    wire access_ph = psel & penable;
    // Write lands only on the edge where pready is sampled high
    wire wr_fire   = access_ph & pready & pwrite & mapped;
    wire wr_ctrl   = wr_fire & sel_ctrl;
    wire wr_ps     = wr_fire & sel_ps;
    wire wr_data   = wr_fire & sel_data;
    wire wr_stat   = wr_fire & sel_stat;

    // Start write: clear-and-start bit written with 1, shifter enabled
    wire start     = wr_ctrl & pwdata[`SSS_B_CLR_START]
                   & pwdata[`SSS_B_SHIFT_EN];

    // ****************************************
    // Internal clock generator
    // ****************************************
    wire int_tick;                          // Half-period tick
    // Idle level equals the edge select bit, so the first edge samples
    wire sck_idle  = edge_sel;
    wire int_run   = ~clk_src & shift_en
                   & (busy_reg | (sck_out != sck_idle));

    sss_tick_gen #(
        .PS_W (PS_W)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (int_run),
        .div     (ps_reg),
        .tick    (int_tick)
    );

    // ****************************************
    // Edge selection
    // ****************************************
    wire ext_rise  = sck_s2_reg & ~sck_s3_reg;
    wire ext_fall  = ~sck_s2_reg & sck_s3_reg;
    wire int_rise  = int_tick & ~sck_out;
    wire int_fall  = int_tick & sck_out;
    wire rise      = clk_src ? ext_rise : int_rise;
    wire fall      = clk_src ? ext_fall : int_fall;
    // Sample and transmit edges swap with the edge select bit
    wire smp_edge  = edge_sel ? fall : rise;
    wire tx_edge   = edge_sel ? rise : fall;
    wire active    = busy_reg & shift_en;
    wire last_bit  = (cnt_reg == `SSS_CNT_LAST);

    // Next bit to drive, taken from the chosen end of the shifter
    wire out_bit   = lsb_first ? shd_reg[0] : shd_reg[7];

    // ****************************************
    // Pin synchronisers
    // ****************************************

    // Two flops ahead of any logic; third flop feeds edge detect
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            si_s1_reg  <= 1'b0;
            si_s2_reg  <= 1'b0;
        end else if (ce) begin
            sck_s1_reg <= sck_in;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            si_s1_reg  <= si_in;
            si_s2_reg  <= si_s1_reg;
        end
    end

    // ****************************************
    // Control, prescaler and status registers
    // ****************************************

    // Software-held settings
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `SSS_CTRL_RST;
            ps_reg   <= `SSS_PS_RST;
            ie_reg   <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                // Start bit is a command, never stored
                ctrl_reg <= pwdata[`SSS_CTRL_W-1:0]
                          & ~(6'h01 << `SSS_B_CLR_START);
            end
            if (wr_ps) begin
                ps_reg <= pwdata[PS_W-1:0];
            end
            if (wr_stat) begin
                ie_reg <= pwdata[`SSS_B_IRQ_EN];
            end
        end
    end

    // ****************************************
    // Shift engine
    // ****************************************

    // Counter, busy and shift data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shd_reg  <= `SSS_DATA_RST;
            cnt_reg  <= `SSS_CNT_RST;
            busy_reg <= 1'b0;
        end else if (ce) begin
            if (start) begin
                // Clear counter and arm a new transfer
                cnt_reg  <= `SSS_CNT_RST;
                busy_reg <= 1'b1;
            end else if (active & smp_edge) begin
                // One bit in per sample edge, in chosen order
                if (lsb_first) begin
                    shd_reg <= {si_s2_reg, shd_reg[7:1]};
                end else begin
                    shd_reg <= {shd_reg[6:0], si_s2_reg};
                end
                cnt_reg <= cnt_reg + 1'b1;
                if (last_bit) begin
                    // Eighth bit ends it; no automatic restart
                    busy_reg <= 1'b0;
                end
            end else if (wr_data & ~busy_reg) begin
                // Byte to send is loaded while idle
                shd_reg <= pwdata[7:0];
            end
        end
    end

    // Serial output: first bit at start, next on each transmit edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_out <= `SSS_SO_IDLE;
        end else if (ce) begin
            if (!xfer_mode) begin
                so_out <= `SSS_SO_IDLE;
            end else if (start) begin
                so_out <= out_bit;
            end else if (active & tx_edge) begin
                so_out <= out_bit;
            end
        end
    end

    // Clock pin: driven only when the internal source is selected
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out  <= 1'b0;
            sck_oe_n <= 1'b0;
        end else if (ce) begin
            sck_oe_n <= clk_src;
            if (int_tick) begin
                sck_out <= ~sck_out;
            end
        end
    end

    // ****************************************
    // Done flag and interrupt request
    // ****************************************
    wire done_set  = active & smp_edge & last_bit & ~start;
    // Completion in the same cycle as service wins over the clear
    wire flag_next = done_set | (flag_reg & ~svc_ack);

    // Flag and masked request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
            irq_req  <= 1'b0;
        end else if (ce) begin
            flag_reg <= flag_next;
            irq_req  <= flag_next & ie_reg;
        end
    end

    // ****************************************
    // APB answer
    // ****************************************
    reg [31:0] rd_data;                     // Read mux

    // Read data selection; unused bits read zero
    always @* begin
        rd_data = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_data[`SSS_CTRL_W-1:0] = ctrl_reg;
            rd_data[`SSS_B_CLR_START] = busy_reg;
        end else if (sel_ps) begin
            rd_data[PS_W-1:0] = ps_reg;
        end else if (sel_data) begin
            rd_data[7:0] = shd_reg;
        end else if (sel_stat) begin
            rd_data[`SSS_B_DONE_FLAG] = flag_reg;
            rd_data[`SSS_B_IRQ_EN] = ie_reg;
        end
    end

    // One wait state, then a single ready cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (access_ph & ~pready) begin
                pready  <= 1'b1;
                pslverr <= ~mapped;
                // Read data moves only on a read answer
                if (!pwrite) begin
                    prdata <= rd_data;
                end
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

endmodule // sss_shifter

`default_nettype wire

// ### hdl/sss_defs.vh
`ifndef SSS_DEFS_VH
`define SSS_DEFS_VH

// ****************************************
// Register map, word index (byte address = 4 x index)
// ****************************************
`define SSS_ADDR_W        12
`define SSS_IDX_CTRL      10'h0e6
`define SSS_IDX_PRESCALE  10'h0e7
`define SSS_IDX_DATA      10'h0e8
`define SSS_IDX_STATUS    10'h0e9

// ****************************************
// Control register fields
// ****************************************
`define SSS_CTRL_W        6
`define SSS_B_CLK_SRC     5
`define SSS_B_BIT_ORDER   4
`define SSS_B_XFER_MODE   3
`define SSS_B_SHIFT_EN    2
`define SSS_B_CLR_START   1
`define SSS_B_EDGE_SEL    0

// ****************************************
// Status register fields
// ****************************************
`define SSS_B_DONE_FLAG   0
`define SSS_B_IRQ_EN      1

// ****************************************
// Reset values and counts
// ****************************************
`define SSS_CTRL_RST      6'h00
`define SSS_PS_RST        8'h00
`define SSS_DATA_RST      8'h00
`define SSS_CNT_RST       3'h0
`define SSS_CNT_LAST      3'h7
`define SSS_DIV_RST       9'h000
`define SSS_SO_IDLE       1'b1

`endif

// ### hdl/sss_tick_gen.v
`include "sss_defs.vh"
`default_nettype none

// ****************************************
// Half-period tick for the internal shift clock
// ****************************************
module sss_tick_gen #(
    parameter PS_W = 8                      // Prescaler width
) (
    input  wire            pclk,
    input  wire            presetn,
    input  wire            ce,
    input  wire            run,
    input  wire [PS_W-1:0] div,
    output reg             tick
);

    reg [PS_W:0] div_cnt_reg;               // Half-period counter
    wire [PS_W:0] div_end;                  // Terminal count

    // Half period is 2*(div+1) clocks, so terminal count is 2*div+1
    assign div_end = {div, 1'b1};

    // Counter runs only while the shifter wants clock edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= `SSS_DIV_RST;
            tick        <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                div_cnt_reg <= `SSS_DIV_RST;
                tick        <= 1'b0;
            end else if (div_cnt_reg == div_end) begin
                div_cnt_reg <= `SSS_DIV_RST;
                tick        <= 1'b1;
            end else begin
                div_cnt_reg <= div_cnt_reg + 1'b1;
                tick        <= 1'b0;
            end
        end
    end

endmodule // sss_tick_gen

`default_nettype wire

// ### verif/sss_properties.sv
`default_nettype none
// ****************************************
// Port checks for the serial shifter
// ****************************************
module sss_props #(
    parameter PS_W = 8                  // Prescaler width
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sck_out,
    input wire logic        sck_oe_n,
    input wire logic        svc_ack,
    input wire logic        irq_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answer comes after exactly one wait state
    a_one_wait: assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("bus answer late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_cause: assert property (pready |-> psel && penable)
        else $error("ready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved");
    // Pin direction moves only through a register write
    a_oe_by_write: assert property ($changed(sck_oe_n) |-> $past(pready && pwrite, 2))
        else $error("clock pin direction moved");
    a_irq_clear: assert property (svc_ack |=> !irq_req)
        else $error("request not cleared");
    a_irq_hold: assert property (irq_req && !svc_ack && !(pready && pwrite) |=> irq_req)
        else $error("request dropped");
    // Internal clock half period is two cycles or more
    a_sck_half: assert property ($changed(sck_out) && !sck_oe_n |=> $stable(sck_out))
        else $error("shift clock too fast");
    c_irq: cover property ($rose(irq_req));
    c_err: cover property (pslverr);
    c_ext: cover property (sck_oe_n);
endmodule // sss_props

bind sss_shifter sss_props #(.PS_W(PS_W)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .svc_ack(svc_ack), .irq_req(irq_req));
`default_nettype wire

// ### verif/sss_partner.sv
`default_nettype none
// ****************************************
// Far-side serial device, master or slave
// ****************************************
module sss_partner (
    input wire logic pclk,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic so_out,
    output logic     sck_in,
    output logic     si_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx, rx;                 // Shift registers
    logic       ord, edg, gen;          // Order, edge, own clock
    logic       act = 1'b0;             // Armed for a frame
    int         cnt, per;               // Sample count, period
    time        tl;                     // Last sample time
    // Wire level: we clock only when the block lets go
    assign sck_in = sck_oe_n ? gen : sck_out;
    assign si_in = ord ? tx[0] : tx[7];
    task load(input logic [7:0] t, input logic o, input logic e);
        tx = t; ord = o; edg = e; gen = e; rx = 8'h00; cnt = 0; tl = 0; act = 1'b0;
    endtask
    // Sixteen clock toggles, standing still after
    task run_clk(input int half);
        repeat (16) begin
            repeat (half) @(posedge pclk);
            gen <= ~gen;
        end
    endtask
    // Sample on the leaving-idle edge, shift on the other
    always @(sck_in) begin
        if (act && sck_in !== edg && cnt < 8) begin
            rx = ord ? {so_out, rx[7:1]} : {rx[6:0], so_out};
            cnt++;
            if (tl != 0) per = ($time - tl) / 8;
            tl = $time;
        end else if (act && sck_in === edg && cnt < 8) begin
            tx = ord ? {~tx[0], tx[7:1]} : {tx[6:0], ~tx[7]};
        end
    end
endmodule // sss_partner
`default_nettype wire

// ### verif/sss_shifter_bench.sv
`include "sss_defs.vh"
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module sss_shifter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic        svc_ack = 0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, sck_in, sck_out, sck_oe_n, si_in, so_out, irq_req;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    logic [7:0]  exp_q[$];              // Bytes the block should receive
    localparam logic [11:0] A_CTL = {`SSS_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_PS = {`SSS_IDX_PRESCALE, 2'b00};
    localparam logic [11:0] A_DAT = {`SSS_IDX_DATA, 2'b00};
    localparam logic [11:0] A_ST = {`SSS_IDX_STATUS, 2'b00};
    always #4 pclk = ~pclk;
    sss_shifter dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .si_in(si_in), .so_out(so_out),
        .svc_ack(svc_ack), .irq_req(irq_req));
    sss_partner p (.pclk(pclk), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
        .so_out(so_out), .sck_in(sck_in), .si_in(si_in));
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            results();
        end
    end
    task results;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask
    // One bus transfer; waits for ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr; psel <= 0; penable <= 0;
    endtask
    // One byte each way, checked against the model
    task xfer(input logic s, o, m, g, ie, input logic [7:0] ps);
        logic [7:0] tx, ptx;
        logic [5:0] c;
        tx = $urandom; ptx = $urandom; c = {s, o, m, 1'b1, 1'b0, g};
        exp_q.push_back(ptx);
        apb(1, A_PS, ps); apb(1, A_DAT, tx); apb(1, A_ST, {ie, 1'b0}); apb(1, A_CTL, c);
        p.load(ptx, o, g);
        // Let the pin clock settle at its new idle level before arming
        repeat (16) @(posedge pclk);
        p.act = 1;
        apb(1, A_CTL, c | 6'h02);
        if (s) begin
            apb(0, A_ST, 0); chk(r[0], 0);
            p.run_clk(6);
        end
        do apb(0, A_ST, 0); while (r[0] !== 1'b1);
        chk(r[1], ie);
        chk(sck_oe_n, s);
        chk(irq_req, ie);
        chk(p.cnt, 8);
        chk(p.rx, m ? tx : 8'hff);
        apb(0, A_DAT, 0); chk(r, exp_q.pop_front());
        if (!s) chk(p.per, 4 * (ps + 1));
        @(posedge pclk) svc_ack <= 1;
        @(posedge pclk) svc_ack <= 0;
        apb(0, A_ST, 0); chk(r[0], 0);
        chk(p.cnt, 8);
        apb(0, A_CTL, 0); chk(r, c);
    endtask
    initial begin
        r = $urandom(18);
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(0, A_CTL, 0); chk(r, 0);
        apb(0, 12'h010, 0); chk(e, 1);
        chk(r, 0);
        // Start with shifting disabled does nothing
        apb(1, A_PS, 1); p.load(8'h5a, 0, 0);
        @(posedge pclk);
        p.act = 1;
        apb(1, A_CTL, 6'h0a);
        repeat (40) @(posedge pclk);
        chk(p.cnt, 0);
        for (int i = 0; i < 16; i++) xfer(i[3], i[2], i[1], i[0], $urandom % 2, 1 + $urandom % 3);
        results();
    end
endmodule // sss_shifter_bench
`default_nettype wire
